// file: shared/dvs_pkg.sv
/*
 * Constants and types shared by both ends of the dual-channel programmable
 * voltage serial control link.
 * Assumes a 10 MHz system clock on both ends.
 */
package dvs_pkg;
    localparam int SYS_CLK_HZ       = 10_000_000;
    localparam int CODE_W           = 8;
    localparam int ADDR_W           = 2;
    localparam int FRAME_BITS       = 1 + ADDR_W + CODE_W;
    localparam int BIT_CNT_W        = 4;
    // host clock: 800 ns period, four system cycles per half period
    localparam int LINK_HALF_CYC    = 4;
    localparam int GAP_CLKS         = 2;
    localparam int DISCARD_CLKS     = 2;
    // chip select filter: lows shorter than this are ignored
    localparam int CS_FILTER_NS     = 90;
    localparam int CS_FILTER_CYC    = (CS_FILTER_NS * SYS_CLK_HZ / 1000 + 999_999) / 1_000_000;
    // store cycle length, typical 4 ms, at most 5 ms
    localparam int STORE_MS         = 4;
    localparam int STORE_CYC        = STORE_MS * (SYS_CLK_HZ / 1000);
    localparam logic [7:0] NV_RESET_CH1 = 8'h80;
    localparam logic [7:0] NV_RESET_CH2 = 8'h80;
    typedef logic [CODE_W-1:0] dvs_code_t;
endpackage

// file: shared/dvs_if.sv
/*
 * Pin-level link between host and device.
 * Assumes the bench resolves the shared data-out wire from serial_out_oe.
 */
`timescale 1ns/1ps
interface dvs_if;
    logic link_clk;
    logic chip_sel;
    logic serial_in;
    logic store_request;
    logic serial_out;
    logic serial_out_oe;
    logic ready_busy_n;
    modport dev  (input link_clk, chip_sel, serial_in, store_request,
                  output serial_out, serial_out_oe, ready_busy_n);
    modport host (output link_clk, chip_sel, serial_in, store_request,
                  input serial_out, serial_out_oe, ready_busy_n);
endinterface

// file: hdl/dvs_sync.sv
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes its input is a pin from outside the sys_clk domain.
 */
`timescale 1ns/1ps
module dvs_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // level
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// file: hdl/dvs_device.sv
/*
 * Device end: receives serial frames, holds two 8-bit channel settings,
 * shifts old contents out, and runs the non-volatile store cycle.
 * Assumes the host obeys frame spacing and keeps clocking during a store.
 */
`timescale 1ns/1ps
// Summary of operation
// - two channels hold 8-bit setting codes
// - power-up loads stored values, no clock needed
// - address and data bits arrive LSB first
// - start bit one; ignore bits before it
// - sample serial input on host clock rise
// - host leaves two clocks between frames
// - address bits select channel one or two
// - accept frames and drive output while selected
// - deselect reloads both channels from storage
// - data output released while deselected
// - short chip select lows are filtered
// - output bits change on host clock rise
// - host clocks throughout the store cycle
// - state holds while the host clock idles
// - store cycle ends within maximum time
// - temporary setting leaves stored value untouched
// - frame is start, address, data; then update
// - store request drops ready; ignore link meanwhile; a deselect during the store still reloads both channels
// - previous contents shift out during transfer
// - unstored data discarded two clocks after reception
module dvs_device
    import dvs_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // link
    dvs_if.dev        link,
    // analog side
    output dvs_code_t voltage_channel_one,
    output dvs_code_t voltage_channel_two,
    output dvs_code_t stored_channel_one,
    output dvs_code_t stored_channel_two
);
    typedef enum logic [1:0] {DVS_IDLE, DVS_SHIFT, DVS_HOLD, DVS_STORE} dvs_state_e;

    logic               clk_s;
    logic               cs_s;
    logic               din_s;
    logic               store_request_s;
    logic               clk_d;
    logic               cs_filt;
    logic [3:0]         cs_low_cnt;
    dvs_state_e         state;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [ADDR_W-1:0]  addr;
    dvs_code_t          data_sr;
    dvs_code_t          out_sr;
    dvs_code_t          store_request_reg;
    logic               store_request_sel;
    logic               store_request_seen;
    logic [1:0]         hold_cnt;
    logic [22:0]        store_cnt;
    logic               rise;
    logic               cs_fall;

    dvs_sync u_sync_clk  (.sys_clk(sys_clk), .rst_b(rst_b), .async_in(link.link_clk),      .sync_out(clk_s));
    dvs_sync u_sync_cs   (.sys_clk(sys_clk), .rst_b(rst_b), .async_in(link.chip_sel),      .sync_out(cs_s));
    dvs_sync u_sync_din  (.sys_clk(sys_clk), .rst_b(rst_b), .async_in(link.serial_in),     .sync_out(din_s));
    dvs_sync u_sync_store_request (.sys_clk(sys_clk), .rst_b(rst_b), .async_in(link.store_request), .sync_out(store_request_s));

    // edges found only on the synchronised clock, so an idle clock changes nothing
    assign rise = clk_s && !clk_d;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) clk_d <= 1'b0;
        else        clk_d <= clk_s;
    end

    // low must persist past the filter window before it counts
    // the counter stops at the window, so a long low costs nothing
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_filt    <= 1'b0;
            cs_low_cnt <= '0;
        end else if (cs_s) begin
            cs_filt    <= 1'b1;
            cs_low_cnt <= '0;
        end else if (cs_low_cnt >= 4'(CS_FILTER_CYC)) begin
            cs_filt    <= 1'b0;
        end else begin
            cs_low_cnt <= cs_low_cnt + 4'h1;
        end
    end
    assign cs_fall = cs_filt && !cs_s && cs_low_cnt >= 4'(CS_FILTER_CYC);

    // frame receiver and store sequencer
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= DVS_IDLE;
            bit_cnt   <= '0;
            addr      <= '0;
            data_sr   <= '0;
            out_sr    <= '0;
            store_request_reg  <= '0;
            store_request_sel  <= 1'b0;
            store_request_seen <= 1'b0;
            hold_cnt  <= '0;
            store_cnt <= '0;
        end else if (state == DVS_STORE) begin
            // link ignored while the store runs
            if (store_cnt == 23'(STORE_CYC - 1)) begin
                state     <= DVS_IDLE;
                store_cnt <= '0;
            end else begin
                store_cnt <= store_cnt + 23'h1;
            end
        end else if (!cs_filt) begin
            state     <= DVS_IDLE;
            bit_cnt   <= '0;
            store_request_seen <= 1'b0;
        end else begin
            // a store request counts only once a frame is under way
            if (store_request_s && state != DVS_IDLE)
                store_request_seen <= 1'b1;
            unique case (state)
                DVS_IDLE: begin
                    if (rise && din_s) begin
                        state   <= DVS_SHIFT;
                        bit_cnt <= '0;
                    end
                end
                DVS_SHIFT: begin
                    if (rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt < 4'(ADDR_W)) begin
                            addr <= {din_s, addr[1]};
                            if (bit_cnt == 4'(ADDR_W - 1))
                                out_sr <= sel_code({din_s, addr[1]});
                        end else begin
                            data_sr <= {din_s, data_sr[7:1]};
                            out_sr  <= {1'b0, out_sr[7:1]};
                        end
                        if (bit_cnt == 4'(FRAME_BITS - 2)) begin
                            state    <= DVS_HOLD;
                            hold_cnt <= '0;
                        end
                    end
                end
                // two link clocks after the last data bit the receiver is free again
                DVS_HOLD: begin
                    if (rise) begin
                        if (hold_cnt == 2'(DISCARD_CLKS - 1)) begin
                            state <= store_request_seen && addr[1] == 1'b0 ? DVS_STORE : DVS_IDLE;
                            store_request_sel <= addr[0];
                            store_request_reg <= data_sr;
                            store_request_seen <= 1'b0;
                        end
                        hold_cnt <= hold_cnt + 2'h1;
                    end
                end
                DVS_STORE: ;
            endcase
        end
    end

    function automatic dvs_code_t sel_code(input logic [1:0] a);
        sel_code = a[0] ? voltage_channel_two : voltage_channel_one;
    endfunction

    // live settings: frame update, deselect reload
    // deselect reload wins over a frame update in the same cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            voltage_channel_one <= NV_RESET_CH1;
            voltage_channel_two <= NV_RESET_CH2;
        end else if (cs_fall) begin
            voltage_channel_one <= stored_channel_one;
            voltage_channel_two <= stored_channel_two;
        end else if (state == DVS_HOLD && rise && hold_cnt == 2'h0 && !addr[1]) begin
            if (addr[0]) voltage_channel_two <= data_sr;
            else         voltage_channel_one <= data_sr;
        end
    end

    // non-volatile image; written only at the end of a store
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stored_channel_one <= NV_RESET_CH1;
            stored_channel_two <= NV_RESET_CH2;
        end else if (state == DVS_STORE && store_cnt == 23'(STORE_CYC - 1)) begin
            if (store_request_sel) stored_channel_two <= store_request_reg;
            else          stored_channel_one <= store_request_reg;
        end
    end

    // pins; data out carries the old code from the last address bit on, so bit 0
    // already stands when the host takes its first sample, and rests at zero otherwise
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            link.serial_out    <= 1'b0;
            link.serial_out_oe <= 1'b0;
            link.ready_busy_n  <= 1'b1;
        end else begin
            link.serial_out    <= state == DVS_SHIFT && bit_cnt >= 4'(ADDR_W) ? out_sr[0] : 1'b0;
            link.serial_out_oe <= cs_filt && state != DVS_STORE;
            link.ready_busy_n  <= state != DVS_STORE;
        end
    end
endmodule

// file: hdl/dvs_host.sv
/*
 * Host end: sends one frame per request, captures the bits shifted back,
 * optionally asks for a store and waits for ready.
 * Assumes one request at a time, taken only while req_ready is high.
 */
`timescale 1ns/1ps
module dvs_host
    import dvs_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // link
    dvs_if.host       link,
    // user requests
    input  wire logic      req_valid,
    input  wire logic [1:0] req_addr,
    input  dvs_code_t      req_data,
    input  wire logic      req_store,
    input  wire logic      req_release,
    output logic           req_ready,
    output logic           rsp_valid,
    output dvs_code_t      rsp_data
);
    typedef enum logic [1:0] {DVH_IDLE, DVH_SEND, DVH_GAP, DVH_WAIT} dvh_state_e;
    dvh_state_e state;
    logic [2:0]  half_cnt;
    logic [3:0]  bit_cnt;
    logic [10:0] frame;
    logic        store;
    dvs_code_t   rx;
    logic        rdy_s;
    logic        dout_s;
    logic        rdy_seen_low;

    dvs_sync u_sync_rdy (.sys_clk(sys_clk), .rst_b(rst_b), .async_in(link.ready_busy_n), .sync_out(rdy_s));
    dvs_sync u_sync_do  (.sys_clk(sys_clk), .rst_b(rst_b), .async_in(link.serial_out),   .sync_out(dout_s));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state         <= DVH_IDLE;
            half_cnt      <= '0;
            bit_cnt       <= '0;
            frame         <= '0;
            store         <= 1'b0;
            rx            <= '0;
            rdy_seen_low  <= 1'b0;
            req_ready     <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_data      <= '0;
            link.link_clk <= 1'b0;
            link.chip_sel <= 1'b0;
            link.serial_in <= 1'b0;
            link.store_request <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            unique case (state)
                DVH_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_release) begin
                        link.chip_sel <= 1'b0;
                    end else if (req_valid && req_ready) begin
                        req_ready     <= 1'b0;
                        link.chip_sel <= 1'b1;
                        frame    <= {req_data, req_addr[1], req_addr[0], 1'b1};
                        store    <= req_store;
                        bit_cnt  <= '0;
                        half_cnt <= '0;
                        state    <= DVH_SEND;
                    end
                end
                DVH_SEND, DVH_GAP, DVH_WAIT: begin
                    // divided clock; data set on low phase, device samples on rise
                    if (half_cnt == 3'(LINK_HALF_CYC - 1)) begin
                        half_cnt      <= '0;
                        link.link_clk <= !link.link_clk;
                        if (link.link_clk) begin
                            if (state == DVH_SEND) begin
                                link.serial_in <= frame[0];
                                frame    <= {1'b0, frame[10:1]};
                                bit_cnt  <= bit_cnt + 4'h1;
                                if (bit_cnt > 4'(ADDR_W + 1))
                                    rx <= {dout_s, rx[7:1]};
                                if (bit_cnt == 4'(FRAME_BITS)) begin
                                    state   <= DVH_GAP;
                                    bit_cnt <= '0;
                                    link.store_request <= store;
                                end
                            end else if (state == DVH_GAP) begin
                                bit_cnt <= bit_cnt + 4'h1;
                                if (bit_cnt == 4'(GAP_CLKS)) begin
                                    rsp_valid <= 1'b1;
                                    rsp_data  <= rx;
                                    state     <= store ? DVH_WAIT : DVH_IDLE;
                                end
                            end else begin
                                // clock kept running until ready returns
                                if (!rdy_s)
                                    rdy_seen_low <= 1'b1;
                                if (rdy_seen_low && rdy_s) begin
                                    link.store_request <= 1'b0;
                                    rdy_seen_low       <= 1'b0;
                                    state              <= DVH_IDLE;
                                end
                            end
                        end
                    end else begin
                        half_cnt <= half_cnt + 3'h1;
                    end
                end
            endcase
        end
    end
endmodule

// file: test/dvs_link_sva.sv
/*
 * Link checker: relates device pin behaviour to host pin behaviour.
 * Assumes it sits beside the host-device interface in the sys_clk domain.
 */
`timescale 1ns/1ps
module dvs_link_sva (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // link pins
    input wire logic link_clk,
    input wire logic chip_sel,
    input wire logic serial_in,
    input wire logic store_request,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic ready_busy_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic [3:0]  since_rise;
    logic [3:0]  since_edge;
    logic [16:0] busy_cnt;
    logic        first_pend;
    logic        start_due;
    // saturating counters keep the checks cheap over the long store cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) since_rise <= 4'hf;
        else if ($rose(link_clk)) since_rise <= 4'h0;
        else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) since_edge <= 4'hf;
        else if ($changed(link_clk)) since_edge <= 4'h0;
        else if (since_edge != 4'hf) since_edge <= since_edge + 4'h1;
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) busy_cnt <= 17'h0;
        else if (ready_busy_n) busy_cnt <= 17'h0;
        else if (busy_cnt != 17'h1ffff) busy_cnt <= busy_cnt + 17'h1;
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) first_pend <= 1'b0;
        else if ($rose(chip_sel)) first_pend <= 1'b1;
        else if ($fell(link_clk)) first_pend <= 1'b0;
    end
    // the clock rise right after select carries no bit; the start bit is set on the following fall
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) start_due <= 1'b0;
        else if ($fell(link_clk)) start_due <= first_pend;
        else if ($rose(link_clk)) start_due <= 1'b0;
    end
    property p_oe_on; $rose(chip_sel) |-> ##[1:8] serial_out_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output not driven after select");
    property p_oe_off; $fell(chip_sel) |-> ##[1:8] !serial_out_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output not released after deselect");
    property p_oe_idle; !chip_sel [*8] |-> !serial_out_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
    property p_busy_on; $rose(store_request) |-> ##[1:300] !ready_busy_n; endproperty
    a_busy_on: assert property (p_busy_on) else $error("store request did not raise busy");
    property p_busy_max; busy_cnt <= 17'd50000; endproperty
    a_busy_max: assert property (p_busy_max) else $error("store cycle longer than 5 ms");
    property p_out_edge;
        ready_busy_n && serial_out_oe && $past(serial_out_oe, 2) && $changed(serial_out) |-> since_rise <= 4'd10;
    endproperty
    a_out_edge: assert property (p_out_edge) else $error("data output moved away from clock rise");
    property p_start_bit; $rose(link_clk) && start_due |-> serial_in; endproperty
    a_start_bit: assert property (p_start_bit) else $error("frame did not open with a one");
    property p_clk_busy; !ready_busy_n |-> since_edge < 4'd12; endproperty
    a_clk_busy: assert property (p_clk_busy) else $error("link clock stopped during store");
    property p_quiet_busy; !ready_busy_n && !$past(ready_busy_n) |-> $stable(serial_out); endproperty
    a_quiet_busy: assert property (p_quiet_busy) else $error("data output moved during store");
endmodule

// file: test/dual_nv_voltage_serial_ctrl_tb.sv
/*
 * Bench: host and device joined over the link, user side of the host driven.
 * Assumes the package constants; one store cycle dominates run time.
 */
`timescale 1ns/1ps
module dual_nv_voltage_serial_ctrl_tb
    import dvs_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        req_valid, req_store, req_release, req_ready, rsp_valid;
    logic [1:0]  req_addr;
    dvs_code_t   req_data, rsp_data, v1, v2, s1, s2;
    dvs_code_t   ch[2];
    dvs_code_t   nv[2];
    int          fails = 0;
    int          n_checks = 0;
    integer      seed = 23;
    logic [31:0] rnd;
    logic [8:0]  rsp_note;
    logic [10:0] cap;
    int          nb = 0;
    logic [8:0]  exp_rsp[$];
    logic [10:0] exp_wire[$];

    always #50 sys_clk = ~sys_clk;

    dvs_if link_bus();
    dvs_device dvs_device_inst (.sys_clk(sys_clk), .rst_b(rst_b), .link(link_bus),
        .voltage_channel_one(v1), .voltage_channel_two(v2), .stored_channel_one(s1), .stored_channel_two(s2));
    dvs_host dvs_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .link(link_bus), .req_valid(req_valid),
        .req_addr(req_addr), .req_data(req_data), .req_store(req_store), .req_release(req_release),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    dvs_link_sva dvs_link_sva_inst (.sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_bus.link_clk),
        .chip_sel(link_bus.chip_sel), .serial_in(link_bus.serial_in), .store_request(link_bus.store_request),
        .serial_out(link_bus.serial_out), .serial_out_oe(link_bus.serial_out_oe),
        .ready_busy_n(link_bus.ready_busy_n));

    task chk(input string nm, input logic [10:0] e, input logic [10:0] s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task wrap_up;
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task wait_rdy;
        int n;
        n = 0;
        while (req_ready !== 1'b1) begin
            if (n == 60000) begin
                fails++;
                wrap_up;
            end
            n++;
            @(negedge sys_clk);
        end
    endtask

    // outputs settle a few cycles after chip select moves, hence the pause
    task chk_state;
        repeat (10) @(negedge sys_clk);
        chk("ch1", {3'h0, ch[0]}, {3'h0, v1});
        chk("ch2", {3'h0, ch[1]}, {3'h0, v2});
        chk("nv1", {3'h0, nv[0]}, {3'h0, s1});
        chk("nv2", {3'h0, nv[1]}, {3'h0, s2});
    endtask

    task xfer(input logic [1:0] a, input dvs_code_t d, input logic st, input logic rel);
        wait_rdy;
        req_valid = 1'b1;
        req_addr = a;
        req_data = d;
        req_store = st;
        exp_wire.push_back({d, a[1], a[0], 1'b1});
        exp_rsp.push_back(a[1] ? 9'h000 : {1'b1, ch[a[0]]});
        if (!a[1]) begin
            ch[a[0]] = d;
            if (st) nv[a[0]] = d;
        end
        @(negedge sys_clk);
        req_valid = 1'b0;
        wait_rdy;
        // release outranks a frame request in the host, so it goes alone once the frame is done
        if (rel) begin
            ch = nv;
            req_release = 1'b1;
            @(negedge sys_clk);
            req_release = 1'b0;
        end
        chk_state;
    endtask

    always @(posedge sys_clk)
        if (rsp_valid === 1'b1) begin
            rsp_note = exp_rsp.size() > 0 ? exp_rsp.pop_front() : 9'h1ff;
            if (rsp_note[8]) chk("rsp_data", {3'h0, rsp_note[7:0]}, {3'h0, rsp_data});
        end

    // wire-side capture: bits before the start bit are skipped
    always @(posedge link_bus.link_clk)
        if (link_bus.chip_sel !== 1'b1 || link_bus.ready_busy_n !== 1'b1) nb = 0;
        else if (nb > 0 || link_bus.serial_in === 1'b1) begin
            cap[nb] = link_bus.serial_in;
            nb++;
            if (nb == FRAME_BITS) begin
                chk("frame", exp_wire.pop_front(), cap);
                nb = 0;
            end
        end

    initial begin
        {req_valid, req_store, req_release} = 3'b000;
        req_addr = 2'b00;
        req_data = 8'h00;
        ch[0] = NV_RESET_CH1;
        ch[1] = NV_RESET_CH2;
        nv = ch;
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        chk("oe", 11'h0, {10'h0, link_bus.serial_out_oe});
        chk("ready", 11'h1, {10'h0, link_bus.ready_busy_n});
        chk_state;
        for (int a = 0; a < 4; a++) begin
            rnd = $random(seed);
            xfer(a[1:0], rnd[7:0], 1'b0, 1'b0);
        end
        xfer(2'b01, 8'h01, 1'b0, 1'b0);
        xfer(2'b01, 8'hfe, 1'b0, 1'b0);
        xfer(2'b00, 8'hff, 1'b0, 1'b1);
        xfer(2'b01, 8'h3c, 1'b1, 1'b1);
        repeat (100) @(negedge sys_clk);
        chk_state;
        for (int i = 0; i < 6; i++) begin
            rnd = $random(seed);
            xfer(rnd[9:8], rnd[7:0], 1'b0, rnd[10]);
        end
        wrap_up;
    end
endmodule
